// ===== hw/ledfs_consts.vh
`ifndef LEDFS_CONSTS_VH
`define LEDFS_CONSTS_VH

// Register offsets
`define LEDFS_ADDR_W             7
`define LEDFS_OFS_STATUS_B       7'h04
`define LEDFS_OFS_STATUS_C       7'h05
`define LEDFS_OFS_THR            7'h06
`define LEDFS_OFS_SLEEP          7'h07
`define LEDFS_OFS_CH1_CUR_LO     7'h08
`define LEDFS_OFS_CH1_CUR_HI     7'h09
`define LEDFS_OFS_CH2_CUR_LO     7'h0A
`define LEDFS_OFS_CH2_CUR_HI     7'h0B
`define LEDFS_OFS_DIM_DIV        7'h0C
`define LEDFS_OFS_CH1_DIM_LO     7'h0D
`define LEDFS_OFS_CH1_DIM_HI     7'h0E
`define LEDFS_OFS_CH2_DIM_LO     7'h0F
`define LEDFS_OFS_CH2_DIM_HI     7'h10
`define LEDFS_OFS_CH1_ON_TIME    7'h11
`define LEDFS_OFS_CH2_ON_TIME    7'h12

// fault_status_b bit positions
`define LEDFS_B_CH1_MAX_DUTY     0
`define LEDFS_B_CH1_BOOT_UV      1
`define LEDFS_B_CH1_THERM_PROT   2
`define LEDFS_B_CH2_MAX_DUTY     3
`define LEDFS_B_CH2_BOOT_UV      4
`define LEDFS_B_CH2_THERM_PROT   5

// fault_status_c bit positions
`define LEDFS_C_CH1_SUMMARY      0
`define LEDFS_C_CH2_SUMMARY      1
`define LEDFS_C_POWER_CYCLE      2
`define LEDFS_C_THERM_WARN       3
`define LEDFS_C_WDOG_LO          4
`define LEDFS_C_WDOG_HI          5
`define LEDFS_C_SUPPLY_UV        6
`define LEDFS_C_STANDALONE       7

// Reset values
`define LEDFS_RST_THR            8'h8A
`define LEDFS_RST_SLEEP          2'h0
`define LEDFS_RST_DIM_DIV        3'h4
`define LEDFS_RST_POWER_CYCLE    1'b1
`define LEDFS_RST_ZERO8          8'h00
`define LEDFS_RST_ZERO2          2'h0
`define LEDFS_RST_ZERO6          6'h00
`define LEDFS_RST_FLAG           1'b0

// Sleep field codes
`define LEDFS_SLEEP_EXIT         2'h0
`define LEDFS_SLEEP_ENTER        2'h1

// Watchdog expiry count
`define LEDFS_WDOG_LIMP          2'h3

`endif

// ===== hw/ledfs_regs.v
`timescale 1ns/1ps
`include "ledfs_consts.vh"

module ledfs_regs #(
	parameter ADDR_W = `LEDFS_ADDR_W
) (
	input  wire              core_clk_i,
	input  wire              rst_n_i,
	// Register port from the serial front end
	input  wire [ADDR_W-1:0] reg_addr_i,
	input  wire [7:0]        reg_wdata_i,
	input  wire              reg_wr_i,
	input  wire              reg_rd_i,
	input  wire              reg_rd_done_i,
	output reg  [7:0]        reg_rdata_o,
	// Analog fault conditions, levels
	input  wire              ch1_therm_shutdown_i,
	input  wire              ch2_therm_shutdown_i,
	input  wire              ch1_boot_undervolt_i,
	input  wire              ch2_boot_undervolt_i,
	input  wire              ch1_max_duty_i,
	input  wire              ch2_max_duty_i,
	input  wire              analog_supply_undervolt_i,
	input  wire [7:0]        temp_adc_msb_i,
	input  wire              ch1_other_fault_i,
	input  wire              ch2_other_fault_i,
	// Events
	input  wire              wdog_expire_i,
	input  wire              standalone_enter_i,
	input  wire              reset_detect_cmd_i,
	input  wire [1:0]        ch_enable_req_i,
	// Control outputs
	output wire [1:0]        ch_enable_o,
	output reg               limp_home_o,
	output reg               sleep_mode_o,
	output wire [9:0]        ch1_current_o,
	output wire [9:0]        ch2_current_o,
	output wire [2:0]        dim_clock_divider_o,
	output wire [9:0]        ch1_dim_width_o,
	output wire [9:0]        ch2_dim_width_o,
	output wire [7:0]        ch1_on_time_o,
	output wire [7:0]        ch2_on_time_o
);

	// Status B flags, bit order as in the register
	reg  [5:0]        stat_b_q;
	reg  [5:0]        stat_b_d;
	reg               supply_uv_q;
	reg  [1:0]        wdog_cnt_q;
	reg               therm_warn_q;
	reg               power_cycle_q;
	reg               standalone_q;
	reg  [ADDR_W-1:0] rd_addr_q;
	reg               rd_pend_q;

	// Control registers
	reg  [7:0]        thr_q;
	reg  [1:0]        sleep_q;
	reg  [1:0]        ch1_cur_lo_q;
	reg  [7:0]        ch1_cur_hi_q;
	reg  [1:0]        ch2_cur_lo_q;
	reg  [7:0]        ch2_cur_hi_q;
	reg  [2:0]        dim_div_q;
	reg  [1:0]        ch1_dim_lo_q;
	reg  [7:0]        ch1_dim_hi_q;
	reg  [1:0]        ch2_dim_lo_q;
	reg  [7:0]        ch2_dim_hi_q;
	reg  [7:0]        ch1_on_q;
	reg  [7:0]        ch2_on_q;

	wire [5:0]        cond_b;
	wire              therm_warn_cond;
	wire              clr_b;
	wire              clr_c;
	wire [1:0]        ch_summary;
	wire [7:0]        stat_b_rd;
	wire [7:0]        stat_c_rd;
	reg  [7:0]        rd_mux;
	wire [1:0]        other_fault;

	// Three flags per channel in fault_status_b, channel one in the low bits
	localparam CH_STRIDE = `LEDFS_B_CH2_MAX_DUTY - `LEDFS_B_CH1_MAX_DUTY;
	localparam NUM_CH    = 2;

	function wr_hit;
		input [ADDR_W-1:0] ofs;
		begin
			wr_hit = reg_wr_i && (reg_addr_i == ofs);
		end
	endfunction

	// A detection in the clearing cycle keeps its flag set
	function sticky_next;
		input flag_q;
		input clr;
		input hit;
		begin
			sticky_next = (flag_q & ~clr) | hit;
		end
	endfunction

	assign cond_b[`LEDFS_B_CH1_MAX_DUTY]   = ch1_max_duty_i;
	assign cond_b[`LEDFS_B_CH1_BOOT_UV]    = ch1_boot_undervolt_i;
	assign cond_b[`LEDFS_B_CH1_THERM_PROT] = ch1_therm_shutdown_i;
	assign cond_b[`LEDFS_B_CH2_MAX_DUTY]   = ch2_max_duty_i;
	assign cond_b[`LEDFS_B_CH2_BOOT_UV]    = ch2_boot_undervolt_i;
	assign cond_b[`LEDFS_B_CH2_THERM_PROT] = ch2_therm_shutdown_i;

	// Warning trips when the upper ADC byte passes the programmed limit
	assign therm_warn_cond = temp_adc_msb_i > thr_q;

	// A flag that sets after the read command is not in the response, yet is
	// still dropped by the clear if its condition has already ended
	// Clear fires at the end of the response transfer for the address read
	assign clr_b = reg_rd_done_i && rd_pend_q && (rd_addr_q == `LEDFS_OFS_STATUS_B);
	assign clr_c = reg_rd_done_i && rd_pend_q && (rd_addr_q == `LEDFS_OFS_STATUS_C);

	// Track which address the pending response belongs to
	// A newer read command retargets a pending clear to its own address
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_addr_q <= {ADDR_W{1'b0}};
			rd_pend_q <= 1'b0;
		end else if (reg_rd_i) begin
			rd_addr_q <= reg_addr_i;
			rd_pend_q <= 1'b1;
		end else if (reg_rd_done_i) begin
			rd_pend_q <= 1'b0;
		end
	end

	// Sticky flags; a live condition always holds its flag through a clear
	always @* begin
		stat_b_d = stat_b_q;
		if (clr_b) begin
			stat_b_d = 6'h00;
		end
		stat_b_d = stat_b_d | cond_b;
	end

	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stat_b_q <= `LEDFS_RST_ZERO6;
		end else begin
			stat_b_q <= stat_b_d;
		end
	end

	// Supply undervoltage stays set until a clearing read finds it gone
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			supply_uv_q <= `LEDFS_RST_FLAG;
		end else begin
			supply_uv_q <= sticky_next(supply_uv_q, clr_c, analog_supply_undervolt_i);
		end
	end

	// Warning follows the same clear rule as the fault flags
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			therm_warn_q <= `LEDFS_RST_FLAG;
		end else begin
			therm_warn_q <= sticky_next(therm_warn_q, clr_c, therm_warn_cond);
		end
	end

	// Only reset sets the power-cycle flag; a clearing read drops it for good
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			power_cycle_q <= `LEDFS_RST_POWER_CYCLE;
		end else begin
			power_cycle_q <= power_cycle_q & ~clr_c;
		end
	end

	// Standalone is a plain status bit: reads never clear it
	// Entering standalone wins over a simultaneous clear command
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			standalone_q <= `LEDFS_RST_FLAG;
		end else if (standalone_enter_i) begin
			standalone_q <= 1'b1;
		end else if (reset_detect_cmd_i) begin
			standalone_q <= 1'b0;
		end
	end

	// Expiry counter saturates; an expiry in the clearing cycle counts as one
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wdog_cnt_q <= `LEDFS_RST_ZERO2;
		end else if (clr_c) begin
			wdog_cnt_q <= wdog_expire_i ? 2'h1 : 2'h0;
		end else if (wdog_expire_i && (wdog_cnt_q != `LEDFS_WDOG_LIMP)) begin
			wdog_cnt_q <= wdog_cnt_q + 2'h1;
		end
	end

	// Limp-home is latched: clearing the count does not return to normal mode
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			limp_home_o <= 1'b0;
		end else if (wdog_expire_i && (wdog_cnt_q == 2'h2)) begin
			limp_home_o <= 1'b1;
		end
	end

	assign other_fault = {ch2_other_fault_i, ch1_other_fault_i};

	// Summary follows the latched status B flags and the live other-fault input, so it drops once both are clear; the protect flag holds
	// the channel off until cleared, and the power-cycle flag blocks both
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_chan
			assign ch_summary[ch] = |stat_b_q[CH_STRIDE*ch +: CH_STRIDE]
				| other_fault[ch];
			assign ch_enable_o[ch] = ch_enable_req_i[ch] & ~power_cycle_q
				& ~stat_b_q[CH_STRIDE*ch + `LEDFS_B_CH1_THERM_PROT];
		end
	endgenerate

	assign stat_b_rd = {2'b00, stat_b_q};
	assign stat_c_rd = {standalone_q, supply_uv_q, wdog_cnt_q, therm_warn_q,
		power_cycle_q, ch_summary};

	// Control register writes; status addresses ignore writes
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			thr_q        <= `LEDFS_RST_THR;
			sleep_q      <= `LEDFS_RST_SLEEP;
			ch1_cur_lo_q <= `LEDFS_RST_ZERO2;
			ch1_cur_hi_q <= `LEDFS_RST_ZERO8;
			ch2_cur_lo_q <= `LEDFS_RST_ZERO2;
			ch2_cur_hi_q <= `LEDFS_RST_ZERO8;
			dim_div_q    <= `LEDFS_RST_DIM_DIV;
			ch1_dim_lo_q <= `LEDFS_RST_ZERO2;
			ch1_dim_hi_q <= `LEDFS_RST_ZERO8;
			ch2_dim_lo_q <= `LEDFS_RST_ZERO2;
			ch2_dim_hi_q <= `LEDFS_RST_ZERO8;
			ch1_on_q     <= `LEDFS_RST_ZERO8;
			ch2_on_q     <= `LEDFS_RST_ZERO8;
		end else begin
			if (wr_hit(`LEDFS_OFS_THR)) begin
				thr_q <= reg_wdata_i;
			end
			if (wr_hit(`LEDFS_OFS_SLEEP)) begin
				sleep_q <= reg_wdata_i[1:0];
			end
			if (wr_hit(`LEDFS_OFS_CH1_CUR_LO)) begin
				ch1_cur_lo_q <= reg_wdata_i[1:0];
			end
			if (wr_hit(`LEDFS_OFS_CH1_CUR_HI)) begin
				ch1_cur_hi_q <= reg_wdata_i;
			end
			if (wr_hit(`LEDFS_OFS_CH2_CUR_LO)) begin
				ch2_cur_lo_q <= reg_wdata_i[1:0];
			end
			if (wr_hit(`LEDFS_OFS_CH2_CUR_HI)) begin
				ch2_cur_hi_q <= reg_wdata_i;
			end
			if (wr_hit(`LEDFS_OFS_DIM_DIV)) begin
				dim_div_q <= reg_wdata_i[2:0];
			end
			if (wr_hit(`LEDFS_OFS_CH1_DIM_LO)) begin
				ch1_dim_lo_q <= reg_wdata_i[1:0];
			end
			if (wr_hit(`LEDFS_OFS_CH1_DIM_HI)) begin
				ch1_dim_hi_q <= reg_wdata_i;
			end
			if (wr_hit(`LEDFS_OFS_CH2_DIM_LO)) begin
				ch2_dim_lo_q <= reg_wdata_i[1:0];
			end
			if (wr_hit(`LEDFS_OFS_CH2_DIM_HI)) begin
				ch2_dim_hi_q <= reg_wdata_i;
			end
			if (wr_hit(`LEDFS_OFS_CH1_ON_TIME)) begin
				ch1_on_q <= reg_wdata_i;
			end
			if (wr_hit(`LEDFS_OFS_CH2_ON_TIME)) begin
				ch2_on_q <= reg_wdata_i;
			end
		end
	end

	// Codes 10 and 11 leave the sleep state as it was
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sleep_mode_o <= 1'b0;
		end else if (sleep_q == `LEDFS_SLEEP_ENTER) begin
			sleep_mode_o <= 1'b1;
		end else if (sleep_q == `LEDFS_SLEEP_EXIT) begin
			sleep_mode_o <= 1'b0;
		end
	end

	// Ten-bit values pair the high byte with the two low bits of the low byte
	assign ch1_current_o       = {ch1_cur_hi_q, ch1_cur_lo_q};
	assign ch2_current_o       = {ch2_cur_hi_q, ch2_cur_lo_q};
	assign dim_clock_divider_o = dim_div_q;
	assign ch1_dim_width_o     = {ch1_dim_hi_q, ch1_dim_lo_q};
	assign ch2_dim_width_o     = {ch2_dim_hi_q, ch2_dim_lo_q};
	assign ch1_on_time_o       = ch1_on_q;
	assign ch2_on_time_o       = ch2_on_q;

	// Read decode; reserved bits and unmapped addresses read zero
	always @* begin
		if (reg_addr_i == `LEDFS_OFS_STATUS_B) begin
			rd_mux = stat_b_rd;
		end else if (reg_addr_i == `LEDFS_OFS_STATUS_C) begin
			rd_mux = stat_c_rd;
		end else if (reg_addr_i == `LEDFS_OFS_THR) begin
			rd_mux = thr_q;
		end else if (reg_addr_i == `LEDFS_OFS_SLEEP) begin
			rd_mux = {6'h00, sleep_q};
		end else if (reg_addr_i == `LEDFS_OFS_CH1_CUR_LO) begin
			rd_mux = {6'h00, ch1_cur_lo_q};
		end else if (reg_addr_i == `LEDFS_OFS_CH1_CUR_HI) begin
			rd_mux = ch1_cur_hi_q;
		end else if (reg_addr_i == `LEDFS_OFS_CH2_CUR_LO) begin
			rd_mux = {6'h00, ch2_cur_lo_q};
		end else if (reg_addr_i == `LEDFS_OFS_CH2_CUR_HI) begin
			rd_mux = ch2_cur_hi_q;
		end else if (reg_addr_i == `LEDFS_OFS_DIM_DIV) begin
			rd_mux = {5'h00, dim_div_q};
		end else if (reg_addr_i == `LEDFS_OFS_CH1_DIM_LO) begin
			rd_mux = {6'h00, ch1_dim_lo_q};
		end else if (reg_addr_i == `LEDFS_OFS_CH1_DIM_HI) begin
			rd_mux = ch1_dim_hi_q;
		end else if (reg_addr_i == `LEDFS_OFS_CH2_DIM_LO) begin
			rd_mux = {6'h00, ch2_dim_lo_q};
		end else if (reg_addr_i == `LEDFS_OFS_CH2_DIM_HI) begin
			rd_mux = ch2_dim_hi_q;
		end else if (reg_addr_i == `LEDFS_OFS_CH1_ON_TIME) begin
			rd_mux = ch1_on_q;
		end else if (reg_addr_i == `LEDFS_OFS_CH2_ON_TIME) begin
			rd_mux = ch2_on_q;
		end else begin
			rd_mux = 8'h00;
		end
	end

	// Snapshot taken at the read command so the response is stable while it shifts
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= `LEDFS_RST_ZERO8;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rd_mux;
		end
	end

endmodule

// ===== tb/ledfs_host.sv
`timescale 1ns/1ps
module ledfs_host (
	input  wire       core_clk_i,
	input  wire [7:0] rdata_i,
	output reg  [6:0] addr_o,
	output reg  [7:0] wdata_o,
	output reg        wr_o,
	output reg        rd_o,
	output reg        rd_done_o
);
	initial begin
		addr_o = 7'h00;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
		rd_done_o = 1'b0;
	end
	// Released lines show the inverse so stale values cannot pass
	task wr(input [6:0] a, input [7:0] d);
		begin
			@(negedge core_clk_i);
			addr_o = a;
			wdata_o = d;
			wr_o = 1'b1;
			@(negedge core_clk_i);
			wr_o = 1'b0;
			addr_o = ~a;
			wdata_o = ~d;
		end
	endtask
	// Without fin the response transfer is never closed
	task rd(input [6:0] a, input fin, output [7:0] d);
		begin
			@(negedge core_clk_i);
			addr_o = a;
			rd_o = 1'b1;
			@(negedge core_clk_i);
			rd_o = 1'b0;
			addr_o = ~a;
			d = rdata_i;
			if (fin) begin
				rd_done_o = 1'b1;
				@(negedge core_clk_i);
				rd_done_o = 1'b0;
			end
		end
	endtask
endmodule

// ===== tb/ledfs_regs_bench.sv
`timescale 1ns/1ps
module ledfs_regs_bench;
	reg        clk;
	reg        rst_n;
	reg  [5:0] fb;
	reg        uv, o1, o2, wd, sa, rdc;
	reg  [7:0] temp;
	reg  [1:0] req;
	wire [6:0] addr;
	wire [7:0] wdata, rdata;
	wire       wr, rd, done, limp, slp;
	wire [1:0] en;
	wire [9:0] c1, c2, w1, w2;
	wire [2:0] div;
	wire [7:0] t1, t2;
	reg  [7:0] d;
	integer    i;
	integer    num_errors = 0;
	integer    samples_checked = 0;
	ledfs_regs dut_u (.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rd_done_i(done), .reg_rdata_o(rdata),
		.ch1_therm_shutdown_i(fb[2]), .ch2_therm_shutdown_i(fb[5]), .ch1_boot_undervolt_i(fb[1]),
		.ch2_boot_undervolt_i(fb[4]), .ch1_max_duty_i(fb[0]), .ch2_max_duty_i(fb[3]),
		.analog_supply_undervolt_i(uv), .temp_adc_msb_i(temp), .ch1_other_fault_i(o1),
		.ch2_other_fault_i(o2), .wdog_expire_i(wd), .standalone_enter_i(sa),
		.reset_detect_cmd_i(rdc), .ch_enable_req_i(req), .ch_enable_o(en), .limp_home_o(limp),
		.sleep_mode_o(slp), .ch1_current_o(c1), .ch2_current_o(c2), .dim_clock_divider_o(div),
		.ch1_dim_width_o(w1), .ch2_dim_width_o(w2), .ch1_on_time_o(t1), .ch2_on_time_o(t2));
	ledfs_host host_u (.core_clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
		.wr_o(wr), .rd_o(rd), .rd_done_o(done));
	function [7:0] pat(input [6:0] a);
		pat = 8'h5A ^ {a[3:0], a[3:0]};
	endfunction
	function [7:0] msk(input [6:0] a);
		case (a)
			7'h07, 7'h08, 7'h0A, 7'h0D, 7'h0F: msk = 8'h03;
			7'h0C: msk = 8'h07;
			default: msk = 8'hFF;
		endcase
	endfunction
	function [9:0] cat(input [7:0] hi, input [7:0] lo);
		cat = {hi, lo[1:0]};
	endfunction
	task chk(input [9:0] g, input [9:0] e);
		begin
			samples_checked = samples_checked + 1;
			if (g !== e) begin
				num_errors = num_errors + 1;
				$display("BAD t=%0t got=%h exp=%h", $time, g, e);
			end
		end
	endtask
	task rchk(input [6:0] a, input fin, input [7:0] e);
		begin
			host_u.rd(a, fin, d);
			chk({2'h0, d}, {2'h0, e});
		end
	endtask
	task w2c;
		repeat (2) @(negedge clk);
	endtask
	task tally_and_finish;
		begin
			$display("checks %0d errors %0d", samples_checked, num_errors);
			if (num_errors == 0 && samples_checked > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	task t_reset;
		begin
			rchk(7'h06, 1'b0, 8'h8A);
			rchk(7'h05, 1'b0, 8'h04);
			rchk(7'h04, 1'b0, 8'h00);
			chk({8'h00, en}, 10'h000);
			chk({7'h00, div}, 10'h004);
			rchk(7'h05, 1'b1, 8'h04);
			rchk(7'h05, 1'b0, 8'h00);
			chk({8'h00, en}, 10'h003);
			@(negedge clk) req = 2'h2;
			@(negedge clk) chk({8'h00, en}, 10'h002);
			req = 2'h3;
			$display("t_reset done");
		end
	endtask
	task t_ctrl;
		begin
			host_u.wr(7'h07, 8'h01);
			w2c;
			chk({9'h000, slp}, 10'h001);
			host_u.wr(7'h07, 8'h02);
			w2c;
			chk({9'h000, slp}, 10'h001);
			host_u.wr(7'h07, 8'h00);
			w2c;
			chk({9'h000, slp}, 10'h000);
			for (i = 6; i <= 18; i = i + 1)
				host_u.wr(i[6:0], pat(i[6:0]));
			for (i = 6; i <= 18; i = i + 1)
				rchk(i[6:0], 1'b0, pat(i[6:0]) & msk(i[6:0]));
			chk(c1, cat(pat(7'h09), pat(7'h08)));
			chk(c2, cat(pat(7'h0B), pat(7'h0A)));
			chk(w1, cat(pat(7'h0E), pat(7'h0D)));
			chk(w2, cat(pat(7'h10), pat(7'h0F)));
			chk({7'h00, div}, {2'h0, pat(7'h0C) & 8'h07});
			chk({2'h0, t1}, {2'h0, pat(7'h11)});
			chk({2'h0, t2}, {2'h0, pat(7'h12)});
			host_u.wr(7'h05, 8'hFF);
			rchk(7'h05, 1'b0, 8'h00);
			host_u.wr(7'h04, 8'hFF);
			rchk(7'h04, 1'b0, 8'h00);
			host_u.wr(7'h13, 8'hFF);
			rchk(7'h13, 1'b0, 8'h00);
			$display("t_ctrl done");
		end
	endtask
	task t_faults;
		begin
			@(negedge clk) fb = 6'h3F;
			@(negedge clk) fb = 6'h08;
			rchk(7'h04, 1'b0, 8'h3F);
			chk({8'h00, en}, 10'h000);
			rchk(7'h04, 1'b1, 8'h3F);
			rchk(7'h04, 1'b0, 8'h08);
			chk({8'h00, en}, 10'h003);
			rchk(7'h05, 1'b0, 8'h02);
			fb = 6'h00;
			rchk(7'h04, 1'b1, 8'h08);
			rchk(7'h04, 1'b0, 8'h00);
			rchk(7'h05, 1'b0, 8'h00);
			$display("t_faults done");
		end
	endtask
	task t_statc;
		begin
			host_u.wr(7'h06, 8'h40);
			temp = 8'h41;
			uv = 1'b1;
			o1 = 1'b1;
			o2 = 1'b1;
			w2c;
			rchk(7'h05, 1'b1, 8'h4B);
			rchk(7'h05, 1'b0, 8'h4B);
			temp = 8'h40;
			uv = 1'b0;
			o1 = 1'b0;
			o2 = 1'b0;
			rchk(7'h05, 1'b1, 8'h48);
			rchk(7'h05, 1'b0, 8'h00);
			$display("t_statc done");
		end
	endtask
	task t_wdog;
		begin
			for (i = 1; i <= 3; i = i + 1) begin
				@(negedge clk) wd = 1'b1;
				@(negedge clk) wd = 1'b0;
				rchk(7'h05, 1'b0, {2'h0, i[1:0], 4'h0});
				chk({9'h000, limp}, {9'h000, i == 3});
			end
			rchk(7'h05, 1'b1, 8'h30);
			rchk(7'h05, 1'b0, 8'h00);
			chk({9'h000, limp}, 10'h001);
			@(negedge clk) sa = 1'b1;
			@(negedge clk) sa = 1'b0;
			rchk(7'h05, 1'b1, 8'h80);
			rchk(7'h05, 1'b0, 8'h80);
			@(negedge clk) rdc = 1'b1;
			@(negedge clk) rdc = 1'b0;
			rchk(7'h05, 1'b0, 8'h00);
			$display("t_wdog done");
		end
	endtask
	task t_repower;
		begin
			@(negedge clk) rst_n = 1'b0;
			w2c;
			rst_n = 1'b1;
			chk({9'h000, limp}, 10'h000);
			rchk(7'h05, 1'b0, 8'h04);
			chk({8'h00, en}, 10'h000);
			rchk(7'h06, 1'b0, 8'h8A);
			$display("t_repower done");
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		#400000;
		num_errors = num_errors + 1;
		tally_and_finish;
	end
	initial begin
		{fb, uv, o1, o2, wd, sa, rdc} = 12'h000;
		temp = 8'h00;
		req = 2'h3;
		rst_n = 1'b0;
		// Fixed delay: a clock edge at time zero must not shorten the reset
		#80;
		rst_n = 1'b1;
		t_reset;
		t_ctrl;
		t_faults;
		t_statc;
		t_wdog;
		t_repower;
		tally_and_finish;
	end
endmodule

// ===== tb/ledfs_regs_chk.sv
`timescale 1ns/1ps
module ledfs_regs_chk #(
	parameter ADDR_W = 7
) (
	input wire              core_clk_i,
	input wire              rst_n_i,
	input wire [ADDR_W-1:0] reg_addr_i,
	input wire [7:0]        reg_wdata_i,
	input wire              reg_wr_i,
	input wire              reg_rd_i,
	input wire [7:0]        reg_rdata_o,
	input wire              ch1_therm_shutdown_i,
	input wire              ch2_therm_shutdown_i,
	input wire              analog_supply_undervolt_i,
	input wire              ch1_other_fault_i,
	input wire              wdog_expire_i,
	input wire [1:0]        ch_enable_req_i,
	input wire [1:0]        ch_enable_o,
	input wire              limp_home_o,
	input wire              sleep_mode_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire rd_c = reg_rd_i && reg_addr_i == 7'h05;
	a_enable_masked: assert property ((ch_enable_o & ~ch_enable_req_i) == 2'h0)
		else $error("enable without request");
	a_ch1_tp_stop: assert property (ch1_therm_shutdown_i |=> !ch_enable_o[0])
		else $error("ch1 runs in thermal shutdown");
	a_ch2_tp_stop: assert property (ch2_therm_shutdown_i |=> !ch_enable_o[1])
		else $error("ch2 runs in thermal shutdown");
	a_limp_sticky: assert property (limp_home_o |=> limp_home_o)
		else $error("limp home left");
	a_limp_cause: assert property ($rose(limp_home_o) |-> $past(wdog_expire_i, 1))
		else $error("limp home without expiry");
	a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data moved");
	a_status_b_rsvd: assert property (reg_rd_i && reg_addr_i == 7'h04 |=>
		reg_rdata_o[7:6] == 2'h0)
		else $error("reserved bits set");
	a_unmapped_zero: assert property (reg_rd_i && reg_addr_i > 7'h12 |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_summary_ch1: assert property (rd_c && ch1_other_fault_i |=> reg_rdata_o[0])
		else $error("ch1 summary missing");
	a_supply_uv: assert property (rd_c && $past(analog_supply_undervolt_i, 1)
		&& $past(rst_n_i, 1) |=> reg_rdata_o[6])
		else $error("supply flag missing");
	a_sleep_enter: assert property (reg_wr_i && reg_addr_i == 7'h07
		&& reg_wdata_i[1:0] == 2'h1 |-> ##[1:2] sleep_mode_o)
		else $error("sleep not entered");
	c_limp: cover property ($rose(limp_home_o));
	c_enabled: cover property (ch_enable_o == 2'h3);
	c_status_c: cover property (rd_c ##1 reg_rdata_o != 8'h00);
endmodule
bind ledfs_regs ledfs_regs_chk #(.ADDR_W(ADDR_W)) chk_u (.core_clk_i(core_clk_i),
	.rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .ch1_therm_shutdown_i(ch1_therm_shutdown_i),
	.ch2_therm_shutdown_i(ch2_therm_shutdown_i), .ch1_other_fault_i(ch1_other_fault_i),
	.analog_supply_undervolt_i(analog_supply_undervolt_i), .wdog_expire_i(wdog_expire_i),
	.ch_enable_req_i(ch_enable_req_i), .ch_enable_o(ch_enable_o), .limp_home_o(limp_home_o),
	.sleep_mode_o(sleep_mode_o));
